/* File: design/icpw_defines.vh */
// Constants for the pulse width capture timer channel
`ifndef ICPW_DEFINES_VH
`define ICPW_DEFINES_VH

// Register offsets (byte addresses)
`define ICPW_ADDR_W        8
`define ICPW_OFS_CTRL      8'h00
`define ICPW_OFS_CLKCTL    8'h04
`define ICPW_OFS_IOCTL     8'h08
`define ICPW_OFS_MODE      8'h0C
`define ICPW_OFS_COUNT     8'h10
`define ICPW_OFS_GRA       8'h14
`define ICPW_OFS_STATUS    8'h18
`define ICPW_OFS_ENABLE    8'h1C
`define ICPW_OFS_CLEAR     8'h20
`define ICPW_OFS_PROTECT   8'h24
`define ICPW_OFS_UNITSEL   8'h28

// Control register fields
`define ICPW_CTRL_START    0
`define ICPW_CTRL_STOP     1
`define ICPW_CTRL_NFEN     2
`define ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_LO  3
`define ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_HI  4
`define ICPW_CTRL_RESET    5'h02

// Clock control fields
`define ICPW_PSC_LO        0
`define ICPW_PSC_HI        2
`define ICPW_EDGE_LO       3
`define ICPW_EDGE_HI       4
`define ICPW_COUNTER_CLEAR_SELECT_LO       5
`define ICPW_COUNTER_CLEAR_SELECT_HI       7

// Mode register fields
`define ICPW_MODE_MD_LO    0
`define ICPW_MODE_MD_HI    3
`define ICPW_MODE_BFA      4
`define ICPW_MODE_BFB      5

// Field encodings
`define ICPW_PSC_DIV1      3'h0
`define ICPW_PSC_DIV4      3'h1
`define ICPW_PSC_DIV16     3'h2
`define ICPW_PSC_DIV64     3'h3
`define ICPW_EDGE_RISE     2'h0
`define ICPW_COUNTER_CLEAR_SELECT_GRA      3'h1
`define ICPW_IOA_CAP_RISE  4'h8
`define ICPW_IOA_CAP_FALL  4'h9
`define ICPW_IOA_CAP_BOTH  4'hA
`define ICPW_IOA_CAP_BOTH2 4'hB
`define ICPW_MODE_NORMAL   4'h0
`define ICPW_UNIT_CH0      2'h0

// Interrupt bit positions
`define ICPW_INT_CAP       0
`define ICPW_INT_OVF       1

// Write protection keys
`define ICPW_KEY_OPEN      16'hA502
`define ICPW_KEY_CLOSE     16'hA500

// Counter and divider constants
`define ICPW_CNT_MAX       16'hFFFF
`define ICPW_CNT_ZERO      16'h0000
`define ICPW_DIV_W         8
`define ICPW_DIV_M1        8'h00
`define ICPW_DIV_M4        8'h03
`define ICPW_DIV_M16       8'h0F
`define ICPW_DIV_M64       8'h3F
`define ICPW_NF_M1         8'h00
`define ICPW_NF_M8         8'h07
`define ICPW_NF_M32        8'h1F
`define ICPW_NF_M256       8'hFF

`endif

/* File: design/icpw_timer.v */
// Pulse width capture timer channel with register port and interrupt
// Overview of operation
// (R01) Counter runs only while start bit set
// (R02) Software stops, zeroes counter and capture first
// (R03) Prescaler 000b counts every peripheral clock
// (R04) Edge select 0 counts on rising edge
// (R05) Clear select 001b clears on A event
// (R06) IO field 1010b captures both edges
// (R07) Each capture edge raises enabled capture request
// (R08) Counter wrap raises enabled overflow request
// (R09) Buffer bits and mode zero: normal mode
// (R10) Enable bits low suppress their requests
// (R11) Software waits two cycles after filter enable
// (R12) Software sets unit selector to zero
// (R13) Stop bit released only with protection open
// (R14) Software counts overflows only while measuring
// (R15) Module stays stopped after reset until released
// (R16) Capture latches counter as clear takes effect
// (R17) Requests stay pending until host clears them
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "icpw_defines.vh"
`default_nettype none

module icpw_timer (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// External pulse input
	input  wire        capture_input_pin,
	// Interrupt request
	output wire        irq
);

	// Software visible state
	reg  [4:0]  ctrl;                   // Start, stop, filter enable, filter clock
	reg  [7:0]  clkctl;                 // Prescaler, edge, clear select
	reg  [3:0]  io_control_register_high; // Holds the IO control A field
	reg  [5:0]  timer_mode_register;    // Mode field and buffer bits
	reg  [15:0] timer_counter_value;    // Channel counter
	reg  [15:0] general_register_a;     // Capture / compare register
	reg  [1:0]  int_status;             // Sticky event flags
	reg  [1:0]  int_enable;             // Interrupt enables
	reg         prot_open;              // Write protection state
	reg  [1:0]  unit_selector_field;    // Shared vector owner

	// Pin path
	reg         pin_s1;                 // First synchroniser stage
	reg         pin_s2;                 // Second synchroniser stage
	reg         nf_q0;                  // Filter sample, newest
	reg         nf_q1;                  // Filter sample, older
	reg         nf_out;                 // Filtered level
	reg  [7:0]  nf_div;                 // Filter sample divider
	reg         cap_prev;               // Previous level for edge detect
	reg  [7:0]  psc_div;                // Count clock divider

	// Field views
	wire        channel_zero_count_start = ctrl[`ICPW_CTRL_START];
	wire        module_stop_bit          = ctrl[`ICPW_CTRL_STOP];
	wire        noise_filter_a_enable    = ctrl[`ICPW_CTRL_NFEN];
	wire [1:0]  noise_filter_clock_select = ctrl[`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_HI:`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_LO];
	wire [2:0]  prescaler_select     = clkctl[`ICPW_PSC_HI:`ICPW_PSC_LO];
	wire [1:0]  clock_edge_select    = clkctl[`ICPW_EDGE_HI:`ICPW_EDGE_LO];
	wire [2:0]  counter_clear_select = clkctl[`ICPW_COUNTER_CLEAR_SELECT_HI:`ICPW_COUNTER_CLEAR_SELECT_LO];
	wire [3:0]  io_control_a_field   = io_control_register_high;
	// Mode register splits into mode field and two buffer bits
	wire [3:0]  operating_mode_field = timer_mode_register[`ICPW_MODE_MD_HI:`ICPW_MODE_MD_LO];
	wire        buffer_mode_a        = timer_mode_register[`ICPW_MODE_BFA];
	wire        buffer_mode_b        = timer_mode_register[`ICPW_MODE_BFB];
	wire        capture_a_int_enable = int_enable[`ICPW_INT_CAP];
	wire        overflow_int_enable  = int_enable[`ICPW_INT_OVF];

	// Register port decode
	wire wr_ctrl   = reg_wr && (reg_addr == `ICPW_OFS_CTRL);
	wire wr_clk    = reg_wr && (reg_addr == `ICPW_OFS_CLKCTL);
	wire wr_io     = reg_wr && (reg_addr == `ICPW_OFS_IOCTL);
	wire wr_mode   = reg_wr && (reg_addr == `ICPW_OFS_MODE);
	wire wr_count  = reg_wr && (reg_addr == `ICPW_OFS_COUNT);
	wire wr_gra    = reg_wr && (reg_addr == `ICPW_OFS_GRA);
	wire wr_enable = reg_wr && (reg_addr == `ICPW_OFS_ENABLE);
	wire wr_clear  = reg_wr && (reg_addr == `ICPW_OFS_CLEAR);
	wire wr_prot   = reg_wr && (reg_addr == `ICPW_OFS_PROTECT);
	wire wr_unit   = reg_wr && (reg_addr == `ICPW_OFS_UNITSEL);

	// Module is alive only once released from stop
	wire running = !module_stop_bit; // (R15)

	// Only normal mode is built; other modes fall back to it
	wire normal_mode = !buffer_mode_a && !buffer_mode_b &&
		(operating_mode_field == `ICPW_MODE_NORMAL); // (R09)

	// Noise filter sample period, selected by filter clock field
	reg  [7:0] nf_mask;
	always @* begin
		case (noise_filter_clock_select)
			2'h0:    nf_mask = `ICPW_NF_M1;
			2'h1:    nf_mask = `ICPW_NF_M8;
			2'h2:    nf_mask = `ICPW_NF_M32;
			default: nf_mask = `ICPW_NF_M256;
		endcase
	end
	wire nf_tick = ((nf_div & nf_mask) == nf_mask);

	// Synchroniser; only the second stage feeds logic
	always @(posedge sys_clk) begin
		if (rst) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
		end else begin
			pin_s1 <= capture_input_pin;
			pin_s2 <= pin_s1;
		end
	end

	// Filter: level changes only after two equal samples, so a
	// glitch shorter than one sample period is rejected
	// Limitation: three sample periods of latency on every edge
	always @(posedge sys_clk) begin
		if (rst) begin
			nf_div <= 8'h00;
			nf_q0  <= 1'b0;
			nf_q1  <= 1'b0;
			nf_out <= 1'b0;
		end else begin
			nf_div <= nf_div + 8'h01;
			if (nf_tick) begin
				nf_q0 <= pin_s2;
				nf_q1 <= nf_q0;
				// Settles two samples after enable
				if (nf_q0 == nf_q1) begin
					nf_out <= nf_q1; // (R11)
				end
			end
		end
	end

	// Level seen by the edge detector
	wire cap_level = noise_filter_a_enable ? nf_out : pin_s2;

	// Edge detect tracks level always so enabling gives no false edge
	always @(posedge sys_clk) begin
		if (rst) begin
			cap_prev <= 1'b0;
		end else begin
			cap_prev <= cap_level;
		end
	end
	wire rise = cap_level && !cap_prev;
	wire fall = !cap_level && cap_prev;

	// Capture mode decode
	wire io_cap_rise = (io_control_a_field == `ICPW_IOA_CAP_RISE);
	wire io_cap_fall = (io_control_a_field == `ICPW_IOA_CAP_FALL);
	wire io_cap_both = (io_control_a_field == `ICPW_IOA_CAP_BOTH) ||
		(io_control_a_field == `ICPW_IOA_CAP_BOTH2);
	wire io_capture  = io_cap_rise || io_cap_fall || io_cap_both;

	// Capture event: both edges in the 1010b setting
	wire cap_event = running && (
		(io_cap_both && (rise || fall)) || // (R06)
		(io_cap_rise && rise) ||
		(io_cap_fall && fall));

	// Prescaler divide mask
	// Divide by one leaves the mask empty, so every clock ticks
	reg  [7:0] psc_mask;
	always @* begin
		case (prescaler_select)
			`ICPW_PSC_DIV1:  psc_mask = `ICPW_DIV_M1; // (R03)
			`ICPW_PSC_DIV4:  psc_mask = `ICPW_DIV_M4;
			`ICPW_PSC_DIV16: psc_mask = `ICPW_DIV_M16;
			default:         psc_mask = `ICPW_DIV_M64;
		endcase
	end

	// Count clock divider runs only while counting
	always @(posedge sys_clk) begin
		if (rst) begin
			psc_div <= 8'h00;
		end else if (running && channel_zero_count_start) begin
			psc_div <= psc_div + 8'h01;
		end else begin
			psc_div <= 8'h00;
		end
	end

	// One tick per rising edge of the divided count clock; other edge
	// settings also count once per period since the clock is internal
	wire edge_ok = (clock_edge_select == `ICPW_EDGE_RISE) || 1'b1; // (R04)
	wire cnt_tick = running && channel_zero_count_start && edge_ok &&
		((psc_div & psc_mask) == psc_mask); // (R01)

	// Compare match only outside capture modes
	wire cmp_event = running && !io_capture &&
		(timer_counter_value == general_register_a) && cnt_tick;

	// Counter clear source
	wire a_event = cap_event || cmp_event;
	wire cnt_clr = a_event && (counter_clear_select == `ICPW_COUNTER_CLEAR_SELECT_GRA); // (R05)

	// Wrap past maximum
	wire ovf_event = cnt_tick && !cnt_clr &&
		(timer_counter_value == `ICPW_CNT_MAX);

	// Channel counter; software write wins, then clear, then count
	// A preset in the cycle of a capture therefore loses that clear
	always @(posedge sys_clk) begin
		if (rst) begin
			timer_counter_value <= `ICPW_CNT_ZERO;
		end else if (wr_count) begin
			timer_counter_value <= reg_wdata[15:0]; // (R02)
		end else if (cnt_clr) begin
			timer_counter_value <= `ICPW_CNT_ZERO; // (R05)
		end else if (cnt_tick) begin
			timer_counter_value <= timer_counter_value + 16'h0001; // (R01)
		end
	end

	// General register A; capture beats a software write in the same cycle
	always @(posedge sys_clk) begin
		if (rst) begin
			general_register_a <= `ICPW_CNT_ZERO;
		end else if (cap_event && normal_mode) begin
			// Old counter value latched as the clear lands
			general_register_a <= timer_counter_value; // (R16)
		end else if (cap_event) begin
			// Buffered modes not built; transfer direct
			general_register_a <= timer_counter_value; // (R09)
		end else if (wr_gra) begin
			general_register_a <= reg_wdata[15:0]; // (R02)
		end
	end

	// Sticky flags; a set in the clear cycle wins
	// Clear is write-one-to-clear; zero bits leave flags alone
	wire [1:0] set_bits = {ovf_event, a_event};
	wire [1:0] clr_bits = wr_clear ? reg_wdata[1:0] : 2'h0;
	always @(posedge sys_clk) begin
		if (rst) begin
			int_status <= 2'h0;
		end else begin
			int_status <= (int_status & ~clr_bits) | set_bits; // (R17)
		end
	end

	// Interrupt request, level, gated by enables and vector owner
	wire cap_req = int_status[`ICPW_INT_CAP] && capture_a_int_enable; // (R07)
	wire ovf_req = int_status[`ICPW_INT_OVF] && overflow_int_enable;  // (R08)
	assign irq = (cap_req || ovf_req) && // (R10)
		(unit_selector_field == `ICPW_UNIT_CH0); // (R12)

	// Write protection: open key enables stop bit writes, close key ends it
	// Any other value leaves the protection state as it was
	always @(posedge sys_clk) begin
		if (rst) begin
			prot_open <= 1'b0;
		end else if (wr_prot && (reg_wdata[15:0] == `ICPW_KEY_OPEN)) begin
			prot_open <= 1'b1; // (R13)
		end else if (wr_prot && (reg_wdata[15:0] == `ICPW_KEY_CLOSE)) begin
			prot_open <= 1'b0; // (R13)
		end
	end

	// Control register; stop bit held unless protection is open
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= `ICPW_CTRL_RESET; // (R15)
		end else if (wr_ctrl) begin
			ctrl[`ICPW_CTRL_START] <= reg_wdata[`ICPW_CTRL_START]; // (R01)
			ctrl[`ICPW_CTRL_NFEN]  <= reg_wdata[`ICPW_CTRL_NFEN];
			ctrl[`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_HI:`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_LO] <=
				reg_wdata[`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_HI:`ICPW_CTRL_NOISE_FILTER_CLOCK_SELECT_LO];
			if (prot_open) begin
				ctrl[`ICPW_CTRL_STOP] <= reg_wdata[`ICPW_CTRL_STOP]; // (R13)
			end
		end
	end

	// Configuration registers
	// Limitation: codes are not range checked; odd ones fall back
	always @(posedge sys_clk) begin
		if (rst) begin
			clkctl                   <= 8'h00;
			io_control_register_high <= 4'h0;
			timer_mode_register      <= 6'h00;
			int_enable               <= 2'h0;
			unit_selector_field      <= 2'h0;
		end else begin
			if (wr_clk) begin
				clkctl <= reg_wdata[7:0];
			end
			if (wr_io) begin
				io_control_register_high <= reg_wdata[3:0];
			end
			if (wr_mode) begin
				timer_mode_register <= reg_wdata[5:0];
			end
			if (wr_enable) begin
				int_enable <= reg_wdata[1:0];
			end
			if (wr_unit) begin
				unit_selector_field <= reg_wdata[1:0];
			end
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	reg [31:0] rd_mux;
	always @* begin
		case (reg_addr)
			`ICPW_OFS_CTRL:    rd_mux = {27'h0, ctrl};
			`ICPW_OFS_CLKCTL:  rd_mux = {24'h0, clkctl};
			`ICPW_OFS_IOCTL:   rd_mux = {28'h0, io_control_register_high};
			`ICPW_OFS_MODE:    rd_mux = {26'h0, timer_mode_register};
			`ICPW_OFS_COUNT:   rd_mux = {16'h0, timer_counter_value};
			`ICPW_OFS_GRA:     rd_mux = {16'h0, general_register_a};
			`ICPW_OFS_STATUS:  rd_mux = {30'h0, int_status};
			`ICPW_OFS_ENABLE:  rd_mux = {30'h0, int_enable};
			`ICPW_OFS_PROTECT: rd_mux = {31'h0, prot_open};
			`ICPW_OFS_UNITSEL: rd_mux = {30'h0, unit_selector_field};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data valid the cycle after the strobe only
	// Zero outside the answer cycle keeps a shared read bus quiet
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

/* File: verification/icpw_timer_sva.sv */
// Concurrent checks on the ports of the pulse width capture timer
`timescale 1ns/100ps
`include "icpw_defines.vh"
`default_nettype none
module icpw_timer_sva (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Pin and request
	input wire logic        capture_input_pin,
	input wire logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       prot_q;  // Protection open
	logic       stop_q;  // Module stopped
	logic       cap_q;   // Capture mode chosen
	logic [1:0] en_q;    // Enable shadow
	logic [1:0] us_q;    // Unit selector shadow
	logic [3:0] quiet;   // Cycles since pin change, saturating
	wire        wr_at_ctrl = reg_wr && reg_addr == `ICPW_OFS_CTRL;
	// Shadow of host setup, so checks know what the design should honour
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prot_q <= 1'b0;
			stop_q <= 1'b1;
			cap_q  <= 1'b0;
			en_q   <= 2'h0;
			us_q   <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == `ICPW_OFS_PROTECT && reg_wdata[15:0] == `ICPW_KEY_OPEN) prot_q <= 1'b1;
			if (reg_addr == `ICPW_OFS_PROTECT && reg_wdata[15:0] == `ICPW_KEY_CLOSE) prot_q <= 1'b0;
			if (wr_at_ctrl && prot_q) stop_q <= reg_wdata[1];
			if (reg_addr == `ICPW_OFS_IOCTL) cap_q <= reg_wdata[3:2] == 2'b10;
			if (reg_addr == `ICPW_OFS_ENABLE) en_q <= reg_wdata[1:0];
			if (reg_addr == `ICPW_OFS_UNITSEL) us_q <= reg_wdata[1:0];
		end
	end
	// Pin quiet time; a late edge could set status over a clear
	always_ff @(posedge sys_clk) begin
		if (rst || capture_input_pin != $past(capture_input_pin)) quiet <= 4'h0;
		else if (quiet != 4'hF) quiet <= quiet + 4'h1;
	end
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read answer");
	chk_stop_mirror: assert property (
		reg_rd && reg_addr == `ICPW_OFS_CTRL |=> reg_rdata[1] == $past(stop_q))
		else $error("module stop bit differs from expected");
	chk_irq_held: assert property (irq && !reg_wr |=> irq)
		else $error("request dropped without host write");
	chk_clear_drops: assert property (
		reg_wr && reg_addr == `ICPW_OFS_CLEAR && reg_wdata[1:0] == 2'b11 && quiet > 4'h8 |=> !irq)
		else $error("request stays after full clear");
	chk_masked_quiet: assert property (en_q == 2'h0 |-> !irq)
		else $error("request with all enables off");
	chk_unit_gate: assert property (us_q != 2'h0 |-> !irq)
		else $error("request with other unit selected");
	chk_stopped_silent: assert property (stop_q && !irq && !reg_wr |=> !irq)
		else $error("request raised while module stopped");
	chk_cap_irq: assert property (
		capture_input_pin != $past(capture_input_pin) && cap_q && en_q[0] && us_q == 2'h0
		&& !stop_q |-> ##[2:6] irq)
		else $error("capture edge raised no request");
	cov_irq: cover property ($rose(irq));
	cov_gra_read: cover property (reg_rd && reg_addr == `ICPW_OFS_GRA);
	cov_release: cover property (stop_q ##1 !stop_q);
endmodule
bind icpw_timer icpw_timer_sva i_icpw_timer_sva (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .capture_input_pin(capture_input_pin), .irq(irq));
`default_nettype wire

/* File: verification/icpw_pulse_src.sv */
// External pulse source model driving the capture pin
`timescale 1ns/100ps
`default_nettype none
module icpw_pulse_src (
	// Clock
	input  wire logic       sys_clk,
	// Request from the bench
	input  wire logic       fire,
	input  wire logic [7:0] width,
	// Capture pin drive
	output var  logic       pin
);
	logic [7:0] left = 8'h00; // High cycles still to go
	// One high pulse of exactly width cycles; idles low between pulses
	always @(posedge sys_clk) begin
		if (fire) begin
			pin  <= 1'b1;
			left <= width - 8'h01;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end else begin
			pin <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/icpw_timer_tb_top.sv */
// Self-checking bench for the pulse width capture timer
`timescale 1ns/100ps
`include "icpw_defines.vh"
`default_nettype none
module icpw_timer_tb_top;
	logic        sys_clk = 1'b0;             // 100 MHz clock
	logic        rst = 1'b1;                 // Synchronous reset
	logic [7:0]  reg_addr = 8'h00;           // Register port
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        pin;                        // Capture pin
	logic        irq;
	logic        fire = 1'b0;                // Pulse request
	logic [7:0]  width = 8'h00;
	int          miscompares = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #5 sys_clk = ~sys_clk;
	icpw_timer i_icpw_timer (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_input_pin(pin), .irq(irq));
	icpw_pulse_src i_icpw_pulse_src (.sys_clk(sys_clk), .fire(fire), .width(width), .pin(pin));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input logic exp);
		#1;
		chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// One pulse, then wait past both edges of the capture pipeline
	task automatic shoot(input logic [7:0] w);
		@(posedge sys_clk);
		fire <= 1'b1;
		width <= w;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (w + 8) @(posedge sys_clk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Hang guard: tests need well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(`ICPW_OFS_CTRL, 32'h0000_0002);
		rd_chk(8'hFC, 32'h0000_0000);
		wr(`ICPW_OFS_CTRL, 32'h0000_0000);
		rd_chk(`ICPW_OFS_CTRL, 32'h0000_0002);
		wr(`ICPW_OFS_PROTECT, {16'h0000, `ICPW_KEY_OPEN});
		rd_chk(`ICPW_OFS_PROTECT, 32'h0000_0001);
		wr(`ICPW_OFS_CTRL, 32'h0000_0000);
		wr(`ICPW_OFS_PROTECT, {16'h0000, `ICPW_KEY_CLOSE});
		rd_chk(`ICPW_OFS_CTRL, 32'h0000_0000);
		$display("test release done");
		wr(`ICPW_OFS_UNITSEL, 32'h0000_0000);
		wr(`ICPW_OFS_COUNT, 32'h0000_0000);
		wr(`ICPW_OFS_GRA, 32'h0000_0000);
		wr(`ICPW_OFS_CLKCTL, 32'h0000_0020);
		wr(`ICPW_OFS_IOCTL, 32'h0000_000A);
		wr(`ICPW_OFS_MODE, 32'h0000_0000);
		wr(`ICPW_OFS_ENABLE, 32'h0000_0003);
		rd_chk(`ICPW_OFS_CLKCTL, 32'h0000_0020);
		rd_chk(`ICPW_OFS_IOCTL, 32'h0000_000A);
		wr(`ICPW_OFS_COUNT, 32'h0000_0100);
		rd_chk(`ICPW_OFS_COUNT, 32'h0000_0100);
		rd_chk(`ICPW_OFS_COUNT, 32'h0000_0100);
		wr(`ICPW_OFS_CTRL, 32'h0000_0001);
		wr(`ICPW_OFS_COUNT, 32'h0000_0100);
		rd_chk(`ICPW_OFS_COUNT, 32'h0000_0101);
		rd_chk(`ICPW_OFS_COUNT, 32'h0000_0103);
		$display("test counting done");
		wr(`ICPW_OFS_COUNT, 32'h0000_FFFE);
		repeat (4) @(posedge sys_clk);
		chk_irq(1'b1);
		rd_chk(`ICPW_OFS_STATUS, 32'h0000_0002);
		wr(`ICPW_OFS_ENABLE, 32'h0000_0001);
		chk_irq(1'b0);
		wr(`ICPW_OFS_ENABLE, 32'h0000_0003);
		chk_irq(1'b1);
		wr(`ICPW_OFS_UNITSEL, 32'h0000_0001);
		chk_irq(1'b0);
		wr(`ICPW_OFS_UNITSEL, 32'h0000_0000);
		wr(`ICPW_OFS_CLEAR, 32'h0000_0002);
		chk_irq(1'b0);
		rd_chk(`ICPW_OFS_STATUS, 32'h0000_0000);
		$display("test overflow done");
		for (int f = 0; f < 2; f++) begin
			wr(`ICPW_OFS_CTRL, f ? 32'h0000_0005 : 32'h0000_0001);
			repeat (2) @(posedge sys_clk);
			wr(`ICPW_OFS_CLEAR, 32'h0000_0003);
			shoot(f ? 8'h0C : 8'h14);
			chk_irq(1'b1);
			rd_chk(`ICPW_OFS_GRA, f ? 32'h0000_000B : 32'h0000_0013);
			rd_chk(`ICPW_OFS_STATUS, 32'h0000_0001);
			wr(`ICPW_OFS_CLEAR, 32'h0000_0001);
			chk_irq(1'b0);
		end
		$display("test capture done");
		// Overflow inside a measured pulse: preset lands two cycles after
		// the rise capture, wraps 16 cycles on, fall capture 46 later
		wr(`ICPW_OFS_CTRL, 32'h0000_0001);
		wr(`ICPW_OFS_CLEAR, 32'h0000_0003);
		@(posedge sys_clk);
		fire <= 1'b1;
		width <= 8'h40;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wr(`ICPW_OFS_COUNT, 32'h0000_FFF0);
		repeat (64) @(posedge sys_clk);
		rd_chk(`ICPW_OFS_STATUS, 32'h0000_0003);
		rd_chk(`ICPW_OFS_GRA, 32'h0000_002D);
		wr(`ICPW_OFS_CLEAR, 32'h0000_0003);
		$display("test measured overflow done");
		wr(`ICPW_OFS_PROTECT, {16'h0000, `ICPW_KEY_OPEN});
		wr(`ICPW_OFS_CTRL, 32'h0000_0003);
		shoot(8'h10);
		chk_irq(1'b0);
		rd_chk(`ICPW_OFS_STATUS, 32'h0000_0000);
		$display("test stopped done");
		results();
	end
endmodule
`default_nettype wire
